// ### uft_frame_timing.sv
// Frame timing counters: bits-left, slot count and periodic threshold.
`timescale 1ns/1ps
`default_nettype none
module uft_frame_timing (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	// Slot length register fields
	input  wire logic [13:0] slot_length,
	input  wire logic        slot_length_toggle,
	// Controller state and scheduling
	input  wire logic        running_state,
	input  wire logic        sof_sent,
	input  wire logic        hcca_write_done,
	input  wire logic        xfer_in_progress,
	// Outputs toward scheduler and status
	output logic             sof_request,
	output logic             hcca_write_req,
	output logic      [15:0] hcca_slot_count,
	output logic             slot_begin_flag,
	output logic             periodic_priority,
	output logic             start_periodic,
	output logic             bit_tick
);
	logic [13:0]       bits_left_count_reg;
	logic [13:0]       bits_left_count_next;
	logic              copied_slot_toggle_reg;
	logic              copied_slot_toggle_next;
	logic [13:0]       reload_len_reg;
	logic [13:0]       reload_len_next;
	logic [15:0]       slot_count_reg;
	logic [15:0]       slot_count_next;
	logic [13:0]       threshold_reg;
	logic [13:0]       threshold_next;
	logic [25:0]       acc_reg;
	logic [25:0]       acc_next;
	logic              tick_reg;
	logic              tick_next;
	logic              run_d_reg;
	logic              run_d_next;
	logic              prio_reg;
	logic              prio_next;
	logic              flag_reg;
	logic              flag_next;
	logic              wreq_reg;
	logic              wreq_next;
	logic [15:0]       hcca_reg;
	logic [15:0]       hcca_next;
	logic [31:0]       rdata_reg;
	logic [31:0]       rdata_next;
	uft_pkg::uft_seq_t seq_reg;
	uft_pkg::uft_seq_t seq_next;
	logic              run_enter;
	logic              reload;

	// -------------------------------------------------------------------------
	// Bit tick and counters
	// -------------------------------------------------------------------------
	// Fractional accumulator keeps the mean tick rate exact at 12 MHz.
	always_comb begin
		logic [26:0] sum;
		sum = {1'b0, acc_reg} + 27'(uft_pkg::BIT_RATE_HZ);
		tick_next = 1'b0;
		acc_next = sum[25:0];
		if (sum >= 27'(uft_pkg::CLK_HZ)) begin
			acc_next = 26'(sum - 27'(uft_pkg::CLK_HZ));
			tick_next = 1'b1;
		end
	end

	assign run_enter = running_state && !run_d_reg;
	// A zero count is held for one bit time, then reloaded at the next boundary.
	assign reload = tick_reg && running_state && (bits_left_count_reg == '0);

	always_comb begin
		// Registered copy of the slot length, so the reload value is nominal right after reset.
		reload_len_next = slot_length;
		bits_left_count_next = bits_left_count_reg;
		copied_slot_toggle_next = copied_slot_toggle_reg;
		slot_count_next = slot_count_reg;
		threshold_next = threshold_reg;
		run_d_next = running_state;
		if (run_enter) begin
			bits_left_count_next = reload_len_reg;
			slot_count_next = slot_count_reg + 16'h0001;
		end else if (running_state && tick_reg) begin
			if (bits_left_count_reg == '0) begin
				bits_left_count_next = reload_len_reg;
				slot_count_next = slot_count_reg + 16'h0001;
			end else begin
				bits_left_count_next = bits_left_count_reg - 14'h0001;
				if (bits_left_count_reg == 14'h0001) begin
					copied_slot_toggle_next = slot_length_toggle;
				end
			end
		end
		// A software write beats the counter update of the same cycle.
		if (reg_wr && reg_addr == uft_pkg::OFS_SLOT_BITS_LEFT) begin
			bits_left_count_next = reg_wdata[uft_pkg::CNT_W-1:0];
			copied_slot_toggle_next = reg_wdata[uft_pkg::TOGGLE_BIT];
		end
		if (reg_wr && reg_addr == uft_pkg::OFS_SLOT_COUNTER_VALUE) begin
			slot_count_next = reg_wdata[uft_pkg::SLOT_W-1:0];
		end
		if (reg_wr && reg_addr == uft_pkg::OFS_PERIODIC_BEGIN) begin
			threshold_next = reg_wdata[uft_pkg::CNT_W-1:0];
		end
	end

	// -------------------------------------------------------------------------
	// Frame boundary sequence and periodic priority
	// -------------------------------------------------------------------------
	always_comb begin
		seq_next = seq_reg;
		wreq_next = 1'b0;
		hcca_next = hcca_reg;
		flag_next = 1'b0;
		prio_next = prio_reg;
		unique case (seq_reg)
			uft_pkg::UFT_IDLE: begin
				if (reload || run_enter) seq_next = uft_pkg::UFT_SOF;
			end
			uft_pkg::UFT_SOF: begin
				if (sof_sent) begin
					seq_next = uft_pkg::UFT_WRITE;
					hcca_next = slot_count_reg;
					wreq_next = 1'b1;
				end
			end
			// The request holds until the shared-area write is acknowledged.
			uft_pkg::UFT_WRITE: begin
				wreq_next = !hcca_write_done;
				if (hcca_write_done) begin
					seq_next = uft_pkg::UFT_IDLE;
					flag_next = 1'b1;
				end
			end
			default: seq_next = uft_pkg::UFT_IDLE;
		endcase
		// A threshold written above the live count only takes effect next frame.
		if (reload || run_enter || !running_state) prio_next = 1'b0;
		else if (bits_left_count_reg == threshold_reg) prio_next = 1'b1;
	end

	// -------------------------------------------------------------------------
	// Register read
	// -------------------------------------------------------------------------
	// Read data stands one cycle and then returns to zero, so no stale word lingers.
	always_comb begin
		rdata_next = uft_pkg::READ_IDLE;
		if (reg_rd) begin
			unique case (reg_addr)
				uft_pkg::OFS_SLOT_BITS_LEFT:
					rdata_next = {copied_slot_toggle_reg, 17'h00000, bits_left_count_reg};
				uft_pkg::OFS_SLOT_COUNTER_VALUE:
					rdata_next = {16'h0000, slot_count_reg};
				uft_pkg::OFS_PERIODIC_BEGIN:
					rdata_next = {18'h00000, threshold_reg};
				default: rdata_next = uft_pkg::READ_IDLE;
			endcase
		end
	end

	// -------------------------------------------------------------------------
	// State registers
	// -------------------------------------------------------------------------
	// One register stage for all state, so a low clock enable freezes reads as well.
	always_ff @(posedge clk) begin
		if (rst) begin
			acc_reg <= '0;
			tick_reg <= 1'b0;
			bits_left_count_reg <= '0;
			copied_slot_toggle_reg <= 1'b0;
			reload_len_reg <= uft_pkg::SLOT_LENGTH_RESET;
			slot_count_reg <= '0;
			threshold_reg <= uft_pkg::THRESHOLD_RESET;
			run_d_reg <= 1'b0;
			seq_reg <= uft_pkg::UFT_IDLE;
			wreq_reg <= 1'b0;
			hcca_reg <= '0;
			flag_reg <= 1'b0;
			prio_reg <= 1'b0;
			rdata_reg <= uft_pkg::READ_IDLE;
		end else if (ce) begin
			acc_reg <= acc_next;
			tick_reg <= tick_next;
			bits_left_count_reg <= bits_left_count_next;
			copied_slot_toggle_reg <= copied_slot_toggle_next;
			reload_len_reg <= reload_len_next;
			slot_count_reg <= slot_count_next;
			threshold_reg <= threshold_next;
			run_d_reg <= run_d_next;
			seq_reg <= seq_next;
			wreq_reg <= wreq_next;
			hcca_reg <= hcca_next;
			flag_reg <= flag_next;
			prio_reg <= prio_next;
			rdata_reg <= rdata_next;
		end
	end

	// -------------------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------------------
	// Periodic work starts only once no control or bulk transfer is open.
	assign start_periodic = prio_reg && !xfer_in_progress;
	assign sof_request = (seq_reg == uft_pkg::UFT_SOF);
	assign hcca_write_req = wreq_reg;
	assign hcca_slot_count = hcca_reg;
	assign slot_begin_flag = flag_reg;
	assign periodic_priority = prio_reg;
	assign bit_tick = tick_reg;
	assign reg_rdata = rdata_reg;
endmodule
`default_nettype wire

// ### uft_pkg.sv
// Package of constants for the frame timing counters block.
// What this block does
// - Keep 14-bit bits-left down counter, readable.
// - Decrement per bit time; reload at zero.
// - Copy length toggle into bit 31 at zero.
// - Reload counter on entering running state.
// - Increment slot count on reload, wrap at FFFFh.
// - Increment slot count on entering running state.
// - Write count to shared area after start-of-frame.
// - Raise slot begin flag after that write.
// - Threshold clears on reset; software programs it.
// - At threshold, periodic lists get priority.
// - Slot count extendable to 32 bits by software.
// - Slot length resets to 11,999 bit times.
package uft_pkg;
	// -------------------------------------------------------------------------
	// Register map
	// -------------------------------------------------------------------------
	localparam logic [7:0] OFS_SLOT_BITS_LEFT     = 8'h38;
	localparam logic [7:0] OFS_SLOT_COUNTER_VALUE = 8'h3C;
	localparam logic [7:0] OFS_PERIODIC_BEGIN     = 8'h40;
	localparam int         CNT_W                  = 14;
	localparam int         SLOT_W                 = 16;
	localparam int         TOGGLE_BIT             = 31;
	localparam logic [13:0] SLOT_LENGTH_RESET     = 14'h2EDF;
	localparam logic [13:0] THRESHOLD_RESET       = 14'h0000;
	localparam logic [31:0] READ_IDLE             = 32'h0000_0000;
	// -------------------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------------------
	localparam int CLK_HZ      = 25_000_000;
	localparam int BIT_RATE_HZ = 12_000_000;
	localparam int ACC_W       = 26;
	// -------------------------------------------------------------------------
	// Boundary sequence
	// -------------------------------------------------------------------------
	typedef enum logic [1:0] {
		UFT_IDLE,
		UFT_SOF,
		UFT_WRITE
	} uft_seq_t;
endpackage

// ### uft_asserts.sv
// Port checker of the frame timing counters.
`timescale 1ns/1ps
`default_nettype none
module uft_asserts (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        sof_sent,
	input wire logic        hcca_write_done,
	input wire logic        xfer_in_progress,
	input wire logic        hcca_write_req,
	input wire logic [15:0] hcca_slot_count,
	input wire logic        slot_begin_flag,
	input wire logic        periodic_priority,
	input wire logic        start_periodic,
	input wire logic        bit_tick
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || !ce);
	sequence s_flag; ##1 slot_begin_flag ##1 !slot_begin_flag; endsequence
	property p_idle; !$past(reg_rd) |-> reg_rdata == 32'h0000_0000; endproperty
	a_idle: assert property (p_idle) else $error("read data not idle");
	property p_flag; hcca_write_done |-> s_flag; endproperty
	a_flag: assert property (p_flag) else $error("flag pulse wrong");
	property p_flag_src; slot_begin_flag |-> $past(hcca_write_done); endproperty
	a_flag_src: assert property (p_flag_src) else $error("flag without write");
	property p_req; sof_sent |=> hcca_write_req; endproperty
	a_req: assert property (p_req) else $error("no write request");
	property p_hold; hcca_write_req && !hcca_write_done |=> hcca_write_req; endproperty
	a_hold: assert property (p_hold) else $error("request dropped");
	property p_cnt; hcca_write_req && $past(hcca_write_req) |-> $stable(hcca_slot_count); endproperty
	a_cnt: assert property (p_cnt) else $error("count moved");
	property p_start; start_periodic == (periodic_priority && !xfer_in_progress); endproperty
	a_start: assert property (p_start) else $error("start wrong");
	property p_gap; bit_tick |=> !bit_tick; endproperty
	a_gap: assert property (p_gap) else $error("tick too wide");
	property p_rate; bit_tick |=> ##[1:2] bit_tick; endproperty
	a_rate: assert property (p_rate) else $error("tick too slow");
endmodule
bind uft_frame_timing uft_asserts i_uft_asserts (.clk, .rst, .ce, .reg_rd, .reg_rdata,
	.sof_sent, .hcca_write_done, .xfer_in_progress, .hcca_write_req, .hcca_slot_count,
	.slot_begin_flag, .periodic_priority, .start_periodic, .bit_tick);
`default_nettype wire

// ### uft_partner.sv
// Scheduler model answering start-of-frame and shared-area write requests.
`timescale 1ns/1ps
`default_nettype none
module uft_partner (
	input  wire logic       clk,
	input  wire logic       sof_request,
	input  wire logic       hcca_write_req,
	input  wire logic [3:0] wait_cycles,
	output logic            sof_sent = 1'b0,
	output logic            hcca_write_done = 1'b0
);
	logic [7:0] s_cnt = 8'h00;
	logic [7:0] w_cnt = 8'h00;
	// A dropped request restarts the wait, so late answers never leak.
	always @(posedge clk) begin
		s_cnt <= sof_request ? s_cnt + 8'h01 : 8'h00;
		w_cnt <= hcca_write_req ? w_cnt + 8'h01 : 8'h00;
		sof_sent <= sof_request && s_cnt == {4'h0, wait_cycles};
		hcca_write_done <= hcca_write_req && w_cnt == {4'h0, wait_cycles};
	end
endmodule
`default_nettype wire

// ### uft_frame_timing_test.sv
// Self-checking testbench of the frame timing counters.
`timescale 1ns/1ps
`default_nettype none
module uft_frame_timing_test;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [13:0] slot_length = uft_pkg::SLOT_LENGTH_RESET;
	logic        slot_length_toggle = 1'b0;
	logic        running_state = 1'b0;
	logic        xfer_in_progress = 1'b0;
	logic [3:0]  wait_cycles = 4'h0;
	logic        sof_request, sof_sent, hcca_write_req, hcca_write_done, slot_begin_flag;
	logic        periodic_priority, start_periodic, bit_tick;
	logic [15:0] hcca_slot_count;
	logic [31:0] reg_rdata, rd_val, ticks = 32'h0, t0;
	int          bad_count = 0;
	int          checks_done = 0;
	int          cycles = 0;
	always #20 clk = ~clk;
	uft_frame_timing i_uft_frame_timing (.clk, .rst, .ce, .reg_addr, .reg_wr, .reg_rd,
		.reg_wdata, .reg_rdata, .slot_length, .slot_length_toggle, .running_state, .sof_sent,
		.hcca_write_done, .xfer_in_progress, .sof_request, .hcca_write_req, .hcca_slot_count,
		.slot_begin_flag, .periodic_priority, .start_periodic, .bit_tick);
	uft_partner i_uft_partner (.clk, .sof_request, .hcca_write_req, .wait_cycles, .sof_sent,
		.hcca_write_done);
	task automatic print_verdict;
		if (bad_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic step;
		@(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		step;
		reg_wr = 1'b0;
		step;
	endtask
	task automatic rd(input logic [7:0] a);
		reg_addr = a;
		reg_rd = 1'b1;
		step;
		reg_rd = 1'b0;
		rd_val = reg_rdata;
		step;
	endtask
	always @(posedge clk) begin
		if (bit_tick)
			ticks <= ticks + 32'h1;
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			print_verdict;
		end
	end
	task automatic t_tick;
		t0 = ticks;
		repeat (uft_pkg::CLK_HZ / 1_000_000) step;
		chk("tick rate", 32'(uft_pkg::BIT_RATE_HZ / 1_000_000), ticks - t0);
	endtask
	task automatic t_regs;
		rd(uft_pkg::OFS_PERIODIC_BEGIN);
		chk("threshold", 32'h0, rd_val);
		wr(uft_pkg::OFS_PERIODIC_BEGIN, 32'h0000_3E67);
		rd(uft_pkg::OFS_PERIODIC_BEGIN);
		chk("threshold", 32'h0000_3E67, rd_val);
		ce = 1'b0;
		wr(uft_pkg::OFS_PERIODIC_BEGIN, 32'h0000_1111);
		ce = 1'b1;
		rd(uft_pkg::OFS_PERIODIC_BEGIN);
		chk("frozen write", 32'h0000_3E67, rd_val);
		wr(8'h44, 32'h0000_1234);
		rd(8'h44);
		chk("unmapped", 32'h0, rd_val);
	endtask
	task automatic t_frames;
		slot_length = 14'h0014;
		slot_length_toggle = 1'b1;
		step;
		running_state = 1'b1;
		@(posedge sof_request);
		#1 t0 = ticks;
		@(posedge sof_request);
		#1 chk("frame ticks", {18'h0, slot_length} + 32'h1, ticks - t0);
		@(posedge hcca_write_req);
		#1 t0 = {16'h0, hcca_slot_count};
		wait_cycles = 4'h5;
		rd(uft_pkg::OFS_SLOT_BITS_LEFT);
		chk("copied toggle", 32'h1, {31'h0, rd_val[31]});
		chk("bits left range", 32'h1, {31'h0, rd_val[13:0] <= slot_length});
		chk("reserved zero", 32'h0, {15'h0, rd_val[30:14]});
		@(posedge hcca_write_req);
		#1 chk("slot count", t0 + 32'h1, {16'h0, hcca_slot_count});
		wr(uft_pkg::OFS_SLOT_COUNTER_VALUE, 32'h0000_FFFF);
		rd(uft_pkg::OFS_SLOT_COUNTER_VALUE);
		chk("slot count read", 32'h0000_FFFF, rd_val);
		@(posedge hcca_write_req);
		#1 chk("wrap", 32'h0, {16'h0, hcca_slot_count});
	endtask
	task automatic t_priority;
		xfer_in_progress = 1'b1;
		wr(uft_pkg::OFS_PERIODIC_BEGIN, 32'h0000_000A);
		@(posedge periodic_priority);
		#1 chk("start held", 32'h0, {31'h0, start_periodic});
		xfer_in_progress = 1'b0;
		#1 chk("start", 32'h1, {31'h0, start_periodic});
		@(posedge sof_request);
		#1 chk("priority clear", 32'h0, {31'h0, periodic_priority});
	endtask
	initial begin
		repeat (12) @(posedge clk);
		#1 rst = 1'b0;
		step;
		t_tick;
		t_regs;
		t_frames;
		t_priority;
		print_verdict;
	end
endmodule
`default_nettype wire
